// ==== design/sbm_consts.svh ====
// Constants for the system bus master port: widths, codes and timing.
`ifndef SBM_CONSTS_SVH
`define SBM_CONSTS_SVH
`define SBM_ADDR_W         20
`define SBM_BASE_ADDR_W    16
`define SBM_DATA_W         8
`define SBM_INT_W          8
`define SBM_CLK_PERIOD_NS  10
`define SBM_BCLK_PERIOD_NS 108
`define SBM_BCLK_LOW_CYC   5
`define SBM_BCLK_HIGH_CYC  6
`define SBM_BCLK_DIV_W     4
`define SBM_ACK_TIMEOUT    1023
`define SBM_TMO_W          10
`define SBM_OP_MRD         2'h0
`define SBM_OP_MWR         2'h1
`define SBM_OP_IORD        2'h2
`define SBM_OP_IOWR        2'h3
`endif

// ==== design/sbm_pkg.sv ====
// Types shared by the system bus master port.
package sbm_pkg;
   typedef enum logic [2:0]
   {
      SBM_IDLE  = 3'b000,
      SBM_ARB   = 3'b001,
      SBM_SETUP = 3'b010,
      SBM_CMD   = 3'b011,
      SBM_HOLD  = 3'b100,
      SBM_REL   = 3'b101
   } sbm_state_t;
endpackage

// ==== design/sbm_clkgen.sv ====
// Divider making the bus clock and constant clock from the system clock.
`timescale 1ns/1ns
`include "sbm_consts.svh"
module sbm_clkgen
   import sbm_pkg::*;
(
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   output logic      bclk_n_ff,
   output logic      constant_clock_n_ff
);
   logic [`SBM_BCLK_DIV_W-1:0] cnt_ff;
   logic [`SBM_BCLK_DIV_W-1:0] nxt_cnt;
   logic                       nxt_bclk;

   // Eleven cycles: five low, six high, giving 110 ns at about 45 percent.
   always_comb
   begin
      nxt_cnt  = cnt_ff + 4'h1;
      nxt_bclk = bclk_n_ff;
      if (cnt_ff == 4'(`SBM_BCLK_LOW_CYC + `SBM_BCLK_HIGH_CYC - 1))
      begin
         nxt_cnt  = 4'h0;
         nxt_bclk = 1'b0;
      end
      else if (cnt_ff == 4'(`SBM_BCLK_LOW_CYC - 1))
      begin
         nxt_bclk = 1'b1;
      end
   end

   // Both clocks share the divider so they never drift apart.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         cnt_ff    <= 4'h0;
         bclk_n_ff <= 1'b0;
         constant_clock_n_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         cnt_ff    <= nxt_cnt;
         bclk_n_ff <= nxt_bclk;
         constant_clock_n_ff <= nxt_bclk;
      end
   end
endmodule

// ==== design/sbm_sync.sv ====
// Two flip-flop synchroniser for a group of level inputs.
`timescale 1ns/1ns
module sbm_sync
   import sbm_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         clock,
   input  wire logic         sys_rst,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] din,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;

   // The first stage feeds only the second, to contain metastability.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s1_ff <= rst_val;
         s2_ff <= rst_val;
      end
      else if (clk_en)
      begin
         s1_ff <= din;
         s2_ff <= s1_ff;
      end
   end

   assign dout = s2_ff;
endmodule

// ==== design/sbm_master.sv ====
// Bus master port driving the shared system backplane bus.
// Operation
// - Twenty address lines select a memory location or an I/O port.
// - Line fifteen is top unless extended lines drive addresses past 65K.
// - Priority-in means no higher master requests; sample it on bus clock.
// - In a daisy chain, priority-out feeds the next lower priority-in.
// - The owner asserts busy on the bus clock; others then stay off.
// - Eight bidirectional data lines, line seven most significant.
// - I/O read command means port address valid; port drives data.
// - I/O write command means port address valid; port takes data.
// - Memory read command means memory address valid; memory drives data.
// - Memory write command means memory address valid; memory stores data.
// - Slave acks when data is ready or taken; master holds the command.
`timescale 1ns/1ns
`include "sbm_consts.svh"
module sbm_master
   import sbm_pkg::*;
(
   input  wire logic                      clock,
   input  wire logic                      sys_rst,
   input  wire logic                      clk_en,
   input  wire logic                      req_valid,
   input  wire logic [1:0]                req_op,
   input  wire logic [`SBM_ADDR_W-1:0]    req_addr,
   input  wire logic                      req_ext,
   input  wire logic [`SBM_DATA_W-1:0]    req_wdata,
   input  wire logic                      req_lock,
   output logic                           req_ready_ff,
   output logic                           rsp_valid_ff,
   output logic [`SBM_DATA_W-1:0]         rsp_rdata_ff,
   output logic                           rsp_timeout_ff,
   output logic                           bclk_n_ff,
   output logic                           constant_clock_ff,
   input  wire logic                      priority_in_n,
   output logic                           priority_out_n_ff,
   output logic                           bus_request_n_ff,
   input  wire logic                      busy_n_in,
   output logic                           busy_n_oe_ff,
   input  wire logic                      common_bus_request_in,
   output logic                           common_bus_request_oe_ff,
   output logic [`SBM_BASE_ADDR_W-1:0]    base_address_lines_ff,
   output logic [3:0]                     extended_address_lines_ff,
   output logic                           addr_oe_ff,
   input  wire logic [`SBM_DATA_W-1:0]    data_lines_in,
   output logic [`SBM_DATA_W-1:0]         data_lines_out_ff,
   output logic                           data_lines_oe_ff,
   output logic                           mem_read_cmd_ff,
   output logic                           mem_write_cmd_ff,
   output logic                           io_read_cmd_ff,
   output logic                           io_write_cmd_ff,
   output logic                           cmd_oe_ff,
   input  wire logic                      transfer_ack,
   input  wire logic                      ram_inhibit,
   output logic                           ram_inhibit_ff,
   input  wire logic [`SBM_INT_W-1:0]     interrupt_lines,
   output logic                           int_pending_ff,
   output logic [2:0]                     int_level_ff,
   input  wire logic                      init_n,
   output logic                           init_oe_ff
);
   // Bus pins, synchronised; a low level means asserted.
   logic [`SBM_INT_W+4:0] pins_raw;
   logic [`SBM_INT_W+4:0] pins_s;
   logic                  prn_s;
   logic                  busy_s;
   logic                  ack_s;
   logic                  inh_s;
   logic [`SBM_INT_W-1:0] int_s;
   logic                  bclk_prev_ff;
   logic                  bclk_edge;
   logic                  init_s;
   sbm_state_t            state_ff;
   sbm_state_t            nxt_state;
   logic [`SBM_TMO_W-1:0] tmo_ff;
   logic [`SBM_TMO_W-1:0] nxt_tmo;
   logic [1:0]            op_ff;
   logic [1:0]            nxt_op;

   // Lowest-numbered asserted line wins.
   function automatic logic [3:0] sbm_prio(input logic [`SBM_INT_W-1:0] act);
      logic [3:0] r;
      r = 4'h0;
      for (int i = `SBM_INT_W - 1; i >= 0; i--)
      begin
         if (act[i])
         begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   assign pins_raw = {init_n, interrupt_lines, ram_inhibit, transfer_ack,
                      busy_n_in, priority_in_n};

   sbm_sync #(.W(`SBM_INT_W + 5)) u_sync
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .din     (pins_raw),
      .rst_val ('1),
      .dout    (pins_s)
   );

   sbm_clkgen u_clk
   (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .bclk_n_ff (bclk_n_ff),
      .constant_clock_n_ff (constant_clock_ff)
   );

   // Decoded active-low pins as active-high internals.
   assign prn_s  = ~pins_s[0];
   assign busy_s = ~pins_s[1];
   assign ack_s  = ~pins_s[2];
   assign inh_s  = ~pins_s[3];
   assign int_s  = ~pins_s[`SBM_INT_W+3:4];
   assign init_s = ~pins_s[`SBM_INT_W+4];
   // Arbitration moves only on a rising bus clock edge, keeping it in step.
   assign bclk_edge = bclk_n_ff & ~bclk_prev_ff;

   // Transfer sequencer: arbitrate, set up, command, wait ack, release.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_tmo   = tmo_ff;
      nxt_op    = op_ff;
      case (state_ff)
         SBM_IDLE:
         begin
            if (req_valid)
            begin
               nxt_op    = req_op;
               nxt_state = SBM_ARB;
            end
         end
         SBM_ARB:
         begin
            if (bclk_edge && prn_s && !busy_s)
            begin
               nxt_state = SBM_SETUP;
            end
         end
         SBM_SETUP:
         begin
            nxt_tmo   = '0;
            nxt_state = SBM_CMD;
         end
         SBM_CMD:
         begin
            nxt_tmo = tmo_ff + 10'h1;
            if (ack_s || tmo_ff == 10'(`SBM_ACK_TIMEOUT))
            begin
               nxt_state = SBM_HOLD;
            end
         end
         SBM_HOLD:
         begin
            nxt_state = SBM_REL;
         end
         SBM_REL:
         begin
            if (bclk_edge)
            begin
               nxt_state = (req_lock && req_valid) ? SBM_ARB : SBM_IDLE;
               nxt_op    = req_op;
            end
         end
         default:
         begin
            nxt_state = SBM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst || init_s)
      begin
         state_ff     <= SBM_IDLE;
         tmo_ff       <= '0;
         op_ff        <= 2'h0;
         bclk_prev_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         state_ff     <= nxt_state;
         tmo_ff       <= nxt_tmo;
         op_ff        <= nxt_op;
         bclk_prev_ff <= bclk_n_ff;
      end
   end

   // Pin drivers, all registered; outputs are the asserted-low levels.
   always_ff @(posedge clock)
   begin
      if (sys_rst || init_s)
      begin
         req_ready_ff              <= 1'b0;
         rsp_valid_ff              <= 1'b0;
         rsp_rdata_ff              <= '0;
         rsp_timeout_ff            <= 1'b0;
         priority_out_n_ff         <= 1'b0;
         bus_request_n_ff          <= 1'b1;
         busy_n_oe_ff              <= 1'b0;
         common_bus_request_oe_ff  <= 1'b0;
         base_address_lines_ff     <= '1;
         extended_address_lines_ff <= '1;
         addr_oe_ff                <= 1'b0;
         data_lines_out_ff         <= '1;
         data_lines_oe_ff          <= 1'b0;
         mem_read_cmd_ff           <= 1'b1;
         mem_write_cmd_ff          <= 1'b1;
         io_read_cmd_ff            <= 1'b1;
         io_write_cmd_ff           <= 1'b1;
         cmd_oe_ff                 <= 1'b0;
         ram_inhibit_ff            <= 1'b0;
         int_pending_ff            <= 1'b0;
         int_level_ff              <= 3'h0;
         init_oe_ff                <= 1'b0;
      end
      else if (clk_en)
      begin
         req_ready_ff   <= (nxt_state == SBM_IDLE) && (state_ff == SBM_IDLE);
         rsp_valid_ff   <= (state_ff == SBM_HOLD);
         // Set on leaving the command unanswered, kept through HOLD so
         // that it stands in the same cycle as the response strobe.
         rsp_timeout_ff <= ((state_ff == SBM_CMD) && !ack_s &&
                            (nxt_state == SBM_HOLD)) ||
                           ((state_ff == SBM_HOLD) && rsp_timeout_ff);
         if (state_ff == SBM_CMD && ack_s && !op_ff[0])
         begin
            rsp_rdata_ff <= ~data_lines_in;
         end
         // Request the bus while we want it and do not yet own it.
         bus_request_n_ff <= !(nxt_state == SBM_ARB);
         common_bus_request_oe_ff <= (nxt_state == SBM_ARB);
         // Inhibit lower masters while we want or hold the bus.
         priority_out_n_ff <= (nxt_state != SBM_IDLE) || !prn_s;
         // Busy covers ownership and outlasts the drive enables.
         busy_n_oe_ff <= (nxt_state == SBM_SETUP) || (nxt_state == SBM_CMD)
                         || (nxt_state == SBM_HOLD)
                         || (nxt_state == SBM_REL);
         addr_oe_ff <= (nxt_state == SBM_SETUP) || (nxt_state == SBM_CMD)
                       || (nxt_state == SBM_HOLD);
         cmd_oe_ff  <= (nxt_state == SBM_SETUP) || (nxt_state == SBM_CMD)
                       || (nxt_state == SBM_HOLD);
         data_lines_oe_ff <= op_ff[0] && ((nxt_state == SBM_SETUP) ||
                             (nxt_state == SBM_CMD) ||
                             (nxt_state == SBM_HOLD));
         if (state_ff == SBM_ARB && nxt_state == SBM_SETUP)
         begin
            // Short addresses keep line fifteen as the top bit.
            base_address_lines_ff <= ~req_addr[15:0];
            extended_address_lines_ff <= req_ext ? ~req_addr[19:16]
                                                 : 4'hf;
            data_lines_out_ff <= ~req_wdata;
         end
         // Commands stay asserted until acknowledge or timeout.
         mem_read_cmd_ff  <= !((nxt_state == SBM_CMD) &&
                               op_ff == `SBM_OP_MRD);
         mem_write_cmd_ff <= !((nxt_state == SBM_CMD) &&
                               op_ff == `SBM_OP_MWR);
         io_read_cmd_ff   <= !((nxt_state == SBM_CMD) &&
                               op_ff == `SBM_OP_IORD);
         io_write_cmd_ff  <= !((nxt_state == SBM_CMD) &&
                               op_ff == `SBM_OP_IOWR);
         ram_inhibit_ff <= inh_s;
         {int_pending_ff, int_level_ff} <= sbm_prio(int_s);
         init_oe_ff <= 1'b0;
      end
   end

   // Assertions on the bus drive discipline.
   a_no_drive_unowned: assert property (@(posedge clock) disable iff (sys_rst)
      addr_oe_ff |-> busy_n_oe_ff)
      else $error("address driven without busy");
   // Initialization drops every enable at once, so it is left out here.
   a_busy_outlasts: assert property (@(posedge clock)
      disable iff (sys_rst || init_s)
      $fell(busy_n_oe_ff) |-> !$past(addr_oe_ff))
      else $error("busy dropped while address driven");
   a_cmd_held_ack: assert property (@(posedge clock) disable iff (sys_rst)
      (!mem_read_cmd_ff && !ack_s && state_ff == SBM_CMD && tmo_ff < 10'h3ff
       && clk_en && !init_s) |=> !mem_read_cmd_ff)
      else $error("read command dropped before acknowledge");
   a_one_cmd: assert property (@(posedge clock) disable iff (sys_rst)
      $countones({~mem_read_cmd_ff, ~mem_write_cmd_ff, ~io_read_cmd_ff,
                  ~io_write_cmd_ff}) <= 1)
      else $error("two commands at once");
   a_common_bus_request_dropped: assert property (@(posedge clock) disable iff (sys_rst)
      busy_n_oe_ff |-> !common_bus_request_oe_ff)
      else $error("common request held while owning");
   a_bus_request_n_owned: assert property (@(posedge clock) disable iff (sys_rst)
      (!bus_request_n_ff && !init_s && clk_en) |=> busy_n_oe_ff
      || !bus_request_n_ff)
      else $error("request dropped without ownership");
   a_data_write_only: assert property (@(posedge clock) disable iff (sys_rst)
      data_lines_oe_ff |-> (mem_read_cmd_ff && io_read_cmd_ff))
      else $error("data driven during a read");
   a_int_prio: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && !init_s && int_s[0]) |=> int_level_ff == 3'h0)
      else $error("line zero not highest priority");
   c_mem_read: cover property (@(posedge clock)
      !mem_read_cmd_ff ##[1:20] rsp_valid_ff);
   c_io_write: cover property (@(posedge clock) !io_write_cmd_ff);
   c_timeout: cover property (@(posedge clock) rsp_timeout_ff);
endmodule

// ==== tb/sbm_slave_model.sv ====
// Behavioural bus slave with memory and I/O ports facing the master port.
`timescale 1ns/1ns
module sbm_slave_model
(
   input  wire logic        clock,
   input  wire logic [19:0] addr_n,
   input  wire logic [7:0]  wdata_n,
   input  wire logic        mrd_n,
   input  wire logic        mwr_n,
   input  wire logic        iord_n,
   input  wire logic        iowr_n,
   input  wire logic        cmd_oe,
   input  wire logic [7:0]  ack_delay,
   input  wire logic        no_ack,
   output logic             ack_n,
   output logic [7:0]       rdata_n,
   output logic             rdata_oe,
   output logic [19:0]      seen_addr,
   output logic [7:0]       seen_wdata
);
   logic [7:0] mem [0:255];
   logic [7:0] io  [0:15];
   logic [7:0] cnt;
   logic       rd;
   logic       wr;

   // Commands are active low and count only while the master drives them.
   assign rd = cmd_oe && !(mrd_n && iord_n);
   assign wr = cmd_oe && !(mwr_n && iowr_n);

   // Known contents, so a read of an unwritten place has a fixed answer.
   initial
   begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
      for (int i = 0; i < 16; i++) io[i] = 8'(i) ^ 8'ha5;
      ack_n = 1'b1;
      rdata_n = 8'hff;
      rdata_oe = 1'b0;
      cnt = 8'h00;
      seen_addr = 20'h00000;
      seen_wdata = 8'h00;
   end

   // Acknowledge after a set delay; until then read data is a moving
   // pattern, so a master that samples early picks up garbage.
   always @(posedge clock)
   begin
      if (!(rd || wr))
      begin
         cnt <= 8'h00;
         ack_n <= 1'b1;
         rdata_oe <= 1'b0;
      end
      else
      begin
         cnt <= cnt + 8'h01;
         if (cnt == 8'h00) seen_addr <= ~addr_n;
         if (cnt == ack_delay && !no_ack)
         begin
            ack_n <= 1'b0;
            if (!mwr_n) mem[~addr_n[7:0]] <= ~wdata_n;
            if (!iowr_n) io[~addr_n[3:0]] <= ~wdata_n;
            if (wr) seen_wdata <= ~wdata_n;
         end
         rdata_oe <= rd;
         if (cnt < ack_delay || no_ack) rdata_n <= cnt;
         else if (!mrd_n) rdata_n <= ~mem[~addr_n[7:0]];
         else rdata_n <= ~io[~addr_n[3:0]];
      end
   end
endmodule

// ==== tb/sbm_tb.sv ====
// Self-checking bench for the system bus master port.
`timescale 1ns/1ns
`include "sbm_consts.svh"
module tb;
   logic        clock, sys_rst, req_valid, req_ext, pri_in_n, oth_busy;
   logic        inh_n, init_n, no_ack;
   logic [1:0]  req_op;
   logic [19:0] req_addr, s_addr;
   logic [7:0]  req_wdata, ints, ack_dly, rdata, dout, s_rd, s_wd, dbus;
   logic        ready, rvalid, rtmo, bclk_n, constant_clock, pout_n, bus_request_n_n, busy_oe;
   logic        common_bus_request_oe, addr_oe, dout_oe, mrd, mwr, iord, iowr, cmd_oe;
   logic        inh_st, int_pend, init_oe, ack_n, s_oe, prev_busy;
   logic [2:0]  int_lvl;
   logic [15:0] base;
   logic [3:0]  ext;
   int          miscompares, tests_run;

   // Open-drain busy and request; undriven data lines float up.
   assign dbus = dout_oe ? dout : (s_oe ? s_rd : 8'hff);

   sbm_master dut (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
      .req_ext(req_ext), .req_wdata(req_wdata), .req_lock(1'b0),
      .req_ready_ff(ready), .rsp_valid_ff(rvalid), .rsp_rdata_ff(rdata),
      .rsp_timeout_ff(rtmo), .bclk_n_ff(bclk_n), .constant_clock_ff(constant_clock),
      .priority_in_n(pri_in_n), .priority_out_n_ff(pout_n),
      .bus_request_n_ff(bus_request_n_n), .busy_n_in(!(busy_oe || oth_busy)),
      .busy_n_oe_ff(busy_oe), .common_bus_request_in(!common_bus_request_oe),
      .common_bus_request_oe_ff(common_bus_request_oe), .base_address_lines_ff(base),
      .extended_address_lines_ff(ext), .addr_oe_ff(addr_oe),
      .data_lines_in(dbus), .data_lines_out_ff(dout),
      .data_lines_oe_ff(dout_oe), .mem_read_cmd_ff(mrd),
      .mem_write_cmd_ff(mwr), .io_read_cmd_ff(iord), .io_write_cmd_ff(iowr),
      .cmd_oe_ff(cmd_oe), .transfer_ack(ack_n), .ram_inhibit(inh_n),
      .ram_inhibit_ff(inh_st), .interrupt_lines(ints),
      .int_pending_ff(int_pend), .int_level_ff(int_lvl), .init_n(init_n),
      .init_oe_ff(init_oe));

   sbm_slave_model slv (.clock(clock), .addr_n({ext, base}),
      .wdata_n(dbus), .mrd_n(mrd), .mwr_n(mwr), .iord_n(iord),
      .iowr_n(iowr), .cmd_oe(cmd_oe), .ack_delay(ack_dly),
      .no_ack(no_ack), .ack_n(ack_n), .rdata_n(s_rd), .rdata_oe(s_oe),
      .seen_addr(s_addr), .seen_wdata(s_wd));

   // The clock runs at 100 MHz.
   always #5 clock = ~clock;

   task automatic chk(input string nm, input logic [31:0] sn,
                      input logic [31:0] ex);
      tests_run++;
      if (sn !== ex)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Address and data stay put until the answer comes back.
   task automatic req(input logic [1:0] op, input logic [19:0] a,
                      input logic e, input logic [7:0] wd);
      @(posedge clock);
      req_op <= op;
      req_addr <= a;
      req_ext <= e;
      req_wdata <= wd;
      req_valid <= 1'b1;
   endtask

   task automatic rsp(output logic [7:0] rd, output logic to, output int n);
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end while (rvalid !== 1'b1 && n < 3000);
      chk("response", n < 3000, 1'b1);
      rd = rdata;
      to = rtmo;
      req_valid <= 1'b0;
   endtask

   task automatic xfer(input logic [1:0] op, input logic [19:0] a,
                       input logic e, input logic [7:0] wd,
                       output logic [7:0] rd, output logic to);
      int n;
      req(op, a, e, wd);
      rsp(rd, to, n);
   endtask

   task automatic t_reset();
      @(posedge clock);
      chk("idle oe", {cmd_oe, addr_oe, dout_oe, busy_oe, init_oe}, 0);
      chk("idle req", {bus_request_n_n, ready}, 2'b11);
   endtask

   // Memory write then read back with extended lines, then a read without them.
   task automatic t_mem();
      logic [7:0] rd;
      logic to;
      xfer(`SBM_OP_MWR, 20'ha53c7, 1'b1, 8'h96, rd, to);
      chk("mw addr", s_addr, 20'ha53c7);
      chk("mw data", s_wd, 8'h96);
      xfer(`SBM_OP_MRD, 20'ha53c7, 1'b1, 8'h00, rd, to);
      chk("mr data", {to, rd}, 9'h096);
      xfer(`SBM_OP_MRD, 20'h08012, 1'b0, 8'h00, rd, to);
      chk("mr16 addr", s_addr, 20'h08012);
      chk("mr16 data", rd, 8'h12 ^ 8'h5a);
   endtask

   task automatic t_io();
      logic [7:0] rd;
      logic to;
      xfer(`SBM_OP_IOWR, 20'h00005, 1'b0, 8'h3c, rd, to);
      chk("iow", {s_addr, s_wd}, 28'h000053c);
      xfer(`SBM_OP_IORD, 20'h00009, 1'b0, 8'h00, rd, to);
      chk("ior other", rd, 8'h09 ^ 8'ha5);
      xfer(`SBM_OP_IORD, 20'h00005, 1'b0, 8'h00, rd, to);
      chk("ior", {to, rd}, 9'h03c);
   endtask

   // A slow slave, then one that never answers.
   task automatic t_ack();
      logic [7:0] rd;
      logic to;
      int n;
      ack_dly <= 8'd60;
      xfer(`SBM_OP_MRD, 20'ha53c7, 1'b1, 8'h00, rd, to);
      chk("slow rd", {to, rd}, 9'h096);
      no_ack <= 1'b1;
      req(`SBM_OP_MWR, 20'h00010, 1'b0, 8'h11);
      rsp(rd, to, n);
      chk("tmo flag", to, 1'b1);
      chk("tmo wait", n >= 1024, 1'b1);
      no_ack <= 1'b0;
      ack_dly <= 8'd3;
   endtask

   task automatic t_arb();
      logic [7:0] rd;
      logic to;
      int n;
      pri_in_n <= 1'b1;
      req(`SBM_OP_MRD, 20'h08012, 1'b0, 8'h00);
      repeat (60) @(posedge clock);
      chk("no prio", {busy_oe, cmd_oe, addr_oe}, 0);
      chk("bus_request_n", bus_request_n_n, 1'b0);
      chk("common_bus_request", common_bus_request_oe, 1'b1);
      chk("prio out", pout_n, 1'b1);
      pri_in_n <= 1'b0;
      oth_busy <= 1'b1;
      repeat (60) @(posedge clock);
      chk("other busy", {busy_oe, cmd_oe}, 0);
      oth_busy <= 1'b0;
      n = 0;
      while (busy_oe !== 1'b1 && n < 100)
      begin
         @(posedge clock);
         n++;
      end
      repeat (3) @(posedge clock);
      chk("common_bus_request drop", common_bus_request_oe, 1'b0);
      rsp(rd, to, n);
      chk("arb rd", rd, 8'h12 ^ 8'h5a);
   endtask

   // Bus clock and constant clock high and low spans.
   task automatic t_clk();
      int n;
      int lo;
      int hi;
      for (int s = 0; s < 2; s++)
      begin
         n = 0;
         do begin @(posedge clock); n++; end
         while ((s ? constant_clock : bclk_n) !== 1'b1 && n < 40);
         do begin @(posedge clock); n++; end
         while ((s ? constant_clock : bclk_n) !== 1'b0 && n < 80);
         lo = 0;
         while ((s ? constant_clock : bclk_n) === 1'b0 && lo < 40)
         begin
            @(posedge clock);
            lo++;
         end
         hi = 0;
         while ((s ? constant_clock : bclk_n) === 1'b1 && hi < 40)
         begin
            @(posedge clock);
            hi++;
         end
         chk("clk low", lo, `SBM_BCLK_LOW_CYC);
         chk("clk high", hi, `SBM_BCLK_HIGH_CYC);
      end
   endtask

   // Each level against line seven; then inhibit and init.
   task automatic t_misc();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clock);
         ints <= ~((8'h01 << i) | 8'h80);
         repeat (5) @(posedge clock);
         chk("int", {int_pend, int_lvl}, {1'b1, 3'(i)});
      end
      ints <= 8'hff;
      inh_n <= 1'b0;
      repeat (5) @(posedge clock);
      chk("int none", int_pend, 1'b0);
      chk("inhibit", inh_st, 1'b1);
      inh_n <= 1'b1;
      repeat (5) @(posedge clock);
      chk("inhibit off", inh_st, 1'b0);
      no_ack <= 1'b1;
      req(`SBM_OP_MRD, 20'h00001, 1'b0, 8'h00);
      repeat (40) @(posedge clock);
      init_n <= 1'b0;
      repeat (5) @(posedge clock);
      chk("init", {cmd_oe, busy_oe, bus_request_n_n}, 3'b001);
      init_n <= 1'b1;
      req_valid <= 1'b0;
      no_ack <= 1'b0;
      repeat (10) @(posedge clock);
   endtask

   // Lines are let go before busy is dropped.
   always @(posedge clock)
   begin
      prev_busy <= busy_oe;
      if (!sys_rst && init_n && prev_busy && !busy_oe)
         chk("rel order", {addr_oe, cmd_oe, dout_oe}, 0);
   end

   initial
   begin
      #300000;
      miscompares++;
      finish_test();
   end

   initial
   begin
      {clock, req_valid, req_ext, pri_in_n, oth_busy, no_ack} = 0;
      {sys_rst, inh_n, init_n} = 3'b111;
      {req_op, req_addr, req_wdata} = 0;
      ints = 8'hff;
      ack_dly = 8'd3;
      prev_busy = 1'b0;
      miscompares = 0;
      tests_run = 0;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clock);
      t_reset();
      t_mem();
      t_io();
      t_ack();
      t_arb();
      t_clk();
      t_misc();
      t_mem();
      finish_test();
   end
endmodule
